// ---- core/psc_host.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module psc_host (
   input wire logic clk,
   input wire logic rstn,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqWrite,
   input wire logic [psc_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [psc_pkg::DATA_W-1:0] reqData,
   output logic rspValid,
   output logic [psc_pkg::DATA_W-1:0] rspData,
   output logic [psc_pkg::ADDR_W-1:0] addressLines,
   output logic selectLowActiveN,
   output logic selectHighActive,
   output logic outputEnableN,
   output logic writeStrobeN,
   input wire logic [psc_pkg::DATA_W-1:0] dataLinesIn,
   output logic [psc_pkg::DATA_W-1:0] dataLinesOut,
   output logic dataLinesOe
);
   import psc_pkg::*;

   // width of the read run counter
   localparam int GUARD_W = $clog2(INVALID_WINDOW_CYC + 1);

   //////////////////////////////////////////////////////////////////////////
   // local state
   psc_state_t state;
   logic [CNT_W-1:0] count;
   logic [DATA_W-1:0] dataSync;
   logic take;
   logic captureNow;
   logic [CNT_W-1:0] sinceWrite;
   logic spacedOk;
   logic [CNT_W-1:0] restRun;
   logic [GUARD_W-1:0] readRun;
   logic restDue;

   //////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction

   function automatic logic isAccess(input psc_state_t st);
      isAccess = (st == PSC_READ) || (st == PSC_WRITE);
   endfunction

   function automatic logic isDone(input logic [CNT_W-1:0] c);
      isDone = (c == '0);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // pin data passes two flops before use
   psc_sync #(.WIDTH(DATA_W)) uSync (
      .clk(clk),
      .rstn(rstn),
      .din(dataLinesIn),
      .dout(dataSync)
   );

   //////////////////////////////////////////////////////////////////////////
   // request handshake, held off by write spacing and select rest
   assign reqReady = (state == PSC_IDLE) && spacedOk && !restDue;
   assign take = reqValid && reqReady;

   //////////////////////////////////////////////////////////////////////////
   // sequencer state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= PSC_IDLE;
      end else begin
         case (state)
            PSC_IDLE: begin
               if (take) begin
                  state <= reqWrite ? PSC_WRITE : PSC_READ;
               end
            end
            PSC_READ: begin
               if (isDone(count)) begin
                  state <= PSC_FLOAT;
               end
            end
            PSC_WRITE: begin
               if (isDone(count)) begin
                  state <= PSC_WREC;
               end
            end
            PSC_WREC: begin
               if (isDone(count)) begin
                  state <= PSC_IDLE;
               end
            end
            PSC_FLOAT: begin
               if (isDone(count)) begin
                  state <= PSC_IDLE;
               end
            end
            default: begin
               state <= PSC_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // sequencer counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
      end else begin
         case (state)
            PSC_IDLE: begin
               if (take) begin
                  count <= reqWrite ? cyc(WR_PULSE) : cyc(RD_CYC + 2);
               end
            end
            PSC_READ: begin
               if (isDone(count)) begin
                  count <= cyc(FLOAT_CYC);
               end else begin
                  count <= count - 1'h1;
               end
            end
            PSC_WRITE: begin
               if (isDone(count)) begin
                  count <= cyc(WR_RECOVER);
               end else begin
                  count <= count - 1'h1;
               end
            end
            PSC_WREC: begin
               if (!isDone(count)) begin
                  count <= count - 1'h1;
               end
            end
            PSC_FLOAT: begin
               if (!isDone(count)) begin
                  count <= count - 1'h1;
               end
            end
            default: begin
               count <= '0;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // address latched on take, stable through cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addressLines <= '0;
      end else if (take) begin
         addressLines <= reqAddr;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // write data latched on take
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dataLinesOut <= '0;
      end else if (take) begin
         dataLinesOut <= reqData;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // low-active select, one edge after address
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         selectLowActiveN <= 1'h1;
      end else begin
         selectLowActiveN <= !isAccess(state);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // high-active select follows the low-active one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         selectHighActive <= 1'h0;
      end else begin
         selectHighActive <= isAccess(state);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // output enable only in read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outputEnableN <= 1'h1;
      end else begin
         outputEnableN <= !(state == PSC_READ);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // write strobe only in write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         writeStrobeN <= 1'h1;
      end else begin
         writeStrobeN <= !(state == PSC_WRITE);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // drive only inside write window, oe high then
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dataLinesOe <= 1'h0;
      end else begin
         dataLinesOe <= (state == PSC_WRITE);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read data capture at end of access
   assign captureNow = (state == PSC_FLOAT) && (count == cyc(FLOAT_CYC)) && !outputEnableN;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rspValid <= 1'h0;
      end else begin
         rspValid <= captureNow;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rspData <= '0;
      end else if (captureNow) begin
         rspData <= dataSync;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // write spacing measured from the last write take
   assign spacedOk = (sinceWrite >= CNT_W'(WR_CYC - 1));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sinceWrite <= CNT_W'(WR_CYC);
      end else if (take && reqWrite) begin
         sinceWrite <= '0;
      end else if (sinceWrite != CNT_W'(WR_CYC)) begin
         sinceWrite <= sinceWrite + 1'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // select rest after a long run of reads
   assign restDue = (readRun == GUARD_W'(INVALID_WINDOW_CYC));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         restRun <= CNT_W'(RD_CYC);
      end else if (!selectLowActiveN) begin
         restRun <= '0;
      end else if (restRun != CNT_W'(RD_CYC)) begin
         restRun <= restRun + 1'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read run length since the last full select rest
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readRun <= '0;
      end else if (restRun == CNT_W'(RD_CYC)) begin
         readRun <= '0;
      end else if (!outputEnableN && !restDue) begin
         readRun <= readRun + 1'h1;
      end
   end
endmodule

// ---- core/psc_pkg.sv ----
package psc_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 20;
   // slowest grade figures, ns, except the invalid window in us
   localparam int READ_CYCLE_MIN_NS = 70;
   localparam int ADDRESS_ACCESS_TIME_NS = 70;
   localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 35;
   localparam int DESELECT_FLOAT_TIME_NS = 25;
   localparam int SELECT_TO_WRITE_END_NS = 60;
   localparam int ADDRESS_LEAD_TO_WRITE_END_NS = 55;
   localparam int DATA_LEAD_TO_WRITE_END_NS = 25;
   localparam int WRITE_PULSE_MIN_NS = 45;
   localparam int WRITE_CYCLE_MIN_NS = 70;
   localparam int ADDRESS_LEAD_TO_WRITE_START_NS = 0;
   localparam int INVALID_WINDOW_US = 15;
   // least times round up
   localparam int RD_CYC = (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_PULSE_A = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_PULSE_B = (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_PULSE = (WR_PULSE_A > WR_PULSE_B) ? WR_PULSE_A : WR_PULSE_B;
   localparam int WR_CYC = (WRITE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_RECOVER = (WR_CYC > WR_PULSE + 1) ? WR_CYC - WR_PULSE : 1;
   localparam int FLOAT_CYC = (DESELECT_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INVALID_WINDOW_CYC = INVALID_WINDOW_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   typedef enum logic [2:0] {
      PSC_IDLE = 3'b000,
      PSC_READ = 3'b001,
      PSC_WRITE = 3'b010,
      PSC_WREC = 3'b011,
      PSC_FLOAT = 3'b100
   } psc_state_t;
endpackage

// ---- core/psc_sync.sv ----
`timescale 1ns/1ps
module psc_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// ---- dv/async_pseudo_static_ram_port_tb_top.sv ----
`timescale 1ns/1ps
module async_pseudo_static_ram_port_tb_top;
   import psc_pkg::*;
   logic clk = 0;
   logic rstn = 0;
   logic reqValid = 0;
   logic reqWrite = 0;
   logic [ADDR_W-1:0] reqAddr = '0;
   logic [DATA_W-1:0] reqData = '0;
   logic reqReady, rspValid, selectLowActiveN, selectHighActive, outputEnableN, writeStrobeN;
   logic dataLinesOe, devOe;
   logic [ADDR_W-1:0] addressLines;
   logic [DATA_W-1:0] rspData, dataLinesOut, devData, dataLinesIn;
   int miscompares = 0;
   int num_checks = 0;
   assign dataLinesIn = dataLinesOe ? dataLinesOut : devOe ? devData : ~devData;
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   psc_host dut_u (.*);
   psc_mem_model mem_u (.*);
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic req(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge clk);
      reqValid <= 1'h1;
      reqWrite <= w;
      reqAddr <= a;
      reqData <= d;
      @(negedge clk);
      while (reqReady !== 1'h1) @(negedge clk);
      @(posedge clk);
      reqValid <= 1'h0;
   endtask
   task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      int n;
      req(1'h0, a, 8'h00);
      for (n = 0; n < 20 && rspValid !== 1'h1; n++) @(negedge clk);
      chk("rspData", {rspValid, rspData}, {1'h1, e});
      chk("read cycles", n, RD_CYC + 2 + FLOAT_CYC);
      @(negedge clk);
      chk("rspValid", rspValid, 1'h0);
   endtask
   task t_idle;
      chk("pins", {selectLowActiveN, selectHighActive, outputEnableN, writeStrobeN}, 4'hB);
      chk("drive", dataLinesOe, 1'h0);
      chk("ready", reqReady, 1'h1);
      chk("address", addressLines, 19'h00000);
   endtask
   task t_corners;
      req(1'h1, 19'h00000, 8'hA5);
      req(1'h1, 19'h7FFFF, 8'h5A);
      rd(19'h00000, 8'hA5);
      rd(19'h7FFFF, 8'h5A);
   endtask
   task t_overwrite;
      req(1'h1, 19'h2AAAA, 8'h3C);
      req(1'h1, 19'h2AAAA, 8'hC3);
      rd(19'h2AAAA, 8'hC3);
   endtask
   task t_reset;
      req(1'h1, 19'h15555, 8'h0F);
      @(posedge clk);
      rstn <= 1'h0;
      @(negedge clk);
      t_idle;
      @(posedge clk);
      rstn <= 1'h1;
      rd(19'h7FFFF, 8'h5A);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'h1;
      @(negedge clk);
      t_idle;
      t_corners;
      t_overwrite;
      t_reset;
      final_report;
   end
   initial begin
      #20000;
      miscompares++;
      final_report;
   end
endmodule

// ---- dv/psc_host_sva.sv ----
`timescale 1ns/1ps
module psc_host_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [psc_pkg::ADDR_W-1:0] addressLines,
   input wire logic selectLowActiveN,
   input wire logic selectHighActive,
   input wire logic outputEnableN,
   input wire logic writeStrobeN,
   input wire logic dataLinesOe
);
   import psc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence lowPulse; !writeStrobeN [*3]; endsequence
   sequence readSpan; !outputEnableN [*6]; endsequence
   a_strobe_width: assert property ($fell(writeStrobeN) |-> lowPulse ##1 writeStrobeN)
      else $error("strobe width");
   a_write_gap: assert property ($rose(writeStrobeN) |-> writeStrobeN [*2])
      else $error("write gap");
   a_write_window: assert property (!writeStrobeN |-> !selectLowActiveN && selectHighActive)
      else $error("write window");
   a_drive_window: assert property (dataLinesOe == (!writeStrobeN && outputEnableN))
      else $error("drive window");
   a_write_addr: assert property (!writeStrobeN && !$past(writeStrobeN)
      |-> $stable(addressLines)) else $error("write address");
   a_read_span: assert property ($fell(outputEnableN) |-> readSpan ##1 outputEnableN)
      else $error("read span");
   a_read_addr: assert property (!outputEnableN && !$past(outputEnableN)
      |-> $stable(addressLines)) else $error("read address");
   a_read_end: assert property ($rose(outputEnableN) |-> selectLowActiveN && !selectHighActive)
      else $error("read end");
endmodule
bind psc_host psc_host_chk chk_u (.*);

// ---- dv/psc_mem_model.sv ----
`timescale 1ns/1ps
module psc_mem_model (
   input wire logic [psc_pkg::ADDR_W-1:0] addressLines,
   input wire logic selectLowActiveN,
   input wire logic selectHighActive,
   input wire logic outputEnableN,
   input wire logic writeStrobeN,
   input wire logic [psc_pkg::DATA_W-1:0] dataLinesIn,
   output logic [psc_pkg::DATA_W-1:0] devData,
   output logic devOe
);
   import psc_pkg::*;
   logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
   logic [DATA_W-1:0] dLate;
   logic sel;
   assign sel = !selectLowActiveN && selectHighActive;
   assign devOe = sel && !outputEnableN && writeStrobeN;
   assign #1 dLate = dataLinesIn;
   always @(negedge (sel && !writeStrobeN)) mem[addressLines] <= dLate;
   always @* if (devOe) devData = mem[addressLines];
endmodule
